// >>> hdl/pss_pkg.sv
// package: constants and types of the program sequencer
package pss_pkg;

    // program counter, instruction and stack geometry
    localparam int          PC_W_SMALL  = 10;
    localparam int          PC_W_LARGE  = 11;
    localparam int          PCL_W       = 8;
    localparam int          INSTR_W     = 14;
    localparam int          STACK_DEPTH = 4;

    // reset vector and register map
    localparam logic [10:0] RESET_VEC   = 11'h000;
    localparam logic [7:0]  PCL_OFS     = 8'h00;
    localparam logic [7:0]  RD_ZERO     = 8'h00;

    // instruction phases, one-hot
    typedef enum logic [3:0] {
        PH_T1 = 4'b0001,
        PH_T2 = 4'b0010,
        PH_T3 = 4'b0100,
        PH_T4 = 4'b1000
    } pss_phase_e;

    // program-flow class of the executing instruction
    typedef enum logic [4:0] {
        OP_SEQ  = 5'b00001,
        OP_JUMP = 5'b00010,
        OP_CALL = 5'b00100,
        OP_RET  = 5'b01000,
        OP_SKIP = 5'b10000
    } pss_op_e;

    // flow request from decode, valid in the last phase
    typedef struct packed {
        pss_op_e     op;
        logic [10:0] target;
    } pss_flow_s;

    // software register port
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pss_reg_req_s;

endpackage : pss_pkg

// >>> hdl/pss_ret_stack.sv
// file: hardware return-address stack, circular, overwrites oldest
`timescale 1ns/100ps
module pss_ret_stack #(
    parameter int DEPTH = pss_pkg::STACK_DEPTH,
    parameter int W     = pss_pkg::PC_W_SMALL
) (
    // clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         sys_rst_i,
    // stack operations
    input  wire logic         push_i,
    input  wire logic         pop_i,
    input  wire logic [W-1:0] push_data_i,
    output logic      [W-1:0] top_o,
    output logic              full_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [AW-1:0] wptr;
        logic [AW:0]   count;
    } pss_stk_s;

    pss_stk_s     st;
    pss_stk_s     next_st;
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] rptr;

    // pointer step with wrap at the depth
    function automatic logic [AW-1:0] pss_step(input logic [AW-1:0] p, input logic up);
        logic [AW-1:0] r;
        r = p;
        if (up) begin
            r = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
        end else begin
            r = (p == '0) ? AW'(DEPTH - 1) : p - 1'b1;
        end
        return r;
    endfunction : pss_step

    assign rptr   = pss_step(st.wptr, 1'b0);
    assign top_o  = mem[rptr];
    assign full_o = (st.count == (AW + 1)'(DEPTH));

    // push saturates the count: a full push overwrites the oldest slot
    always_comb begin
        next_st = st;
        if (push_i) begin
            next_st.wptr = pss_step(st.wptr, 1'b1);
            if (!full_o) begin
                next_st.count = st.count + 1'b1;
            end
        end else if (pop_i && (st.count != '0)) begin
            next_st.wptr  = rptr;
            next_st.count = st.count - 1'b1;
        end
    end

    // reset empties the stack by pointer and count only
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // storage has no reset; never visible to software
    always_ff @(posedge ref_clk_i) begin
        if (push_i) begin
            mem[st.wptr] <= push_data_i;
        end
    end

endmodule : pss_ret_stack

// >>> hdl/pss_sequencer.sv
// file: program sequencer with phase generator, counter and stack control
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/100ps
module pss_sequencer #(
    parameter int PC_W        = pss_pkg::PC_W_SMALL,
    parameter int STACK_DEPTH = pss_pkg::STACK_DEPTH,
    parameter int INSTR_W     = pss_pkg::INSTR_W
) (
    // clock and reset
    input  wire logic               ref_clk_i,
    input  wire logic               sys_rst_i,
    // program memory
    output logic      [PC_W-1:0]    prog_addr_o,
    output logic                    prog_rd_o,
    input  wire logic [INSTR_W-1:0] instr_i,
    // decode and execute
    output logic      [3:0]         phase_o,
    output logic      [INSTR_W-1:0] exec_instr_o,
    output logic                    exec_valid_o,
    input  wire pss_pkg::pss_flow_s flow_i,
    // interrupt controller
    input  wire logic               int_req_i,
    input  wire logic [10:0]        int_vector_i,
    output logic                    int_ack_o,
    output logic                    int_pend_o,
    // software register port
    input  wire logic [7:0]         reg_addr_i,
    input  wire logic [7:0]         reg_wdata_i,
    input  wire logic               reg_wr_i,
    input  wire logic               reg_rd_i,
    output logic      [7:0]         reg_rdata_o
);

    typedef struct packed {
        pss_pkg::pss_phase_e phase;
        logic [PC_W-1:0]     pc;
        logic [INSTR_W-1:0]  instr;
        logic                valid;
        logic                int_flag;
        logic                pcl_pend;
        logic [7:0]          pcl_data;
        logic [7:0]          rdata;
        logic                ack;
    } pss_seq_s;

    pss_seq_s         st;
    pss_seq_s         next_st;

    // boundary decisions
    logic             boundary;
    logic             redirect;
    logic             push;
    logic             pop;
    logic             ack;
    logic             pcl_hit;
    logic [PC_W-1:0]  next_pc;
    logic [PC_W-1:0]  top;
    logic             full;

    // return stack; its pointer and contents have no software path
    pss_ret_stack #(
        .DEPTH       (STACK_DEPTH),
        .W           (PC_W)
    ) u_stack (
        .ref_clk_i   (ref_clk_i),
        .sys_rst_i   (sys_rst_i),
        .push_i      (push),
        .pop_i       (pop),
        .push_data_i (st.pc),
        .top_o       (top),
        .full_o      (full)
    );

    // the last phase closes the instruction cycle
    assign boundary = (st.phase == pss_pkg::PH_T4);
    assign pcl_hit  = reg_wr_i && (reg_addr_i == pss_pkg::PCL_OFS);

    // flow decision taken once per instruction cycle
    always_comb begin
        redirect = 1'b0;
        push     = 1'b0;
        pop      = 1'b0;
        ack      = 1'b0;
        next_pc  = st.pc + 1'b1;
        if (boundary && st.valid) begin
            unique case (flow_i.op)
                pss_pkg::OP_JUMP: begin
                    next_pc  = flow_i.target[PC_W-1:0];
                    redirect = 1'b1;
                end
                pss_pkg::OP_CALL: begin
                    next_pc  = flow_i.target[PC_W-1:0];
                    redirect = 1'b1;
                    push     = 1'b1;
                end
                pss_pkg::OP_RET: begin
                    next_pc  = top;
                    redirect = 1'b1;
                    pop      = 1'b1;
                end
                pss_pkg::OP_SKIP: begin
                    redirect = 1'b1;
                end
                default: begin
                end
            endcase
        end
        // low byte write: jump inside the current page only
        if (boundary && !redirect && st.pcl_pend) begin
            next_pc  = {st.pc[PC_W-1:pss_pkg::PCL_W], st.pcl_data};
            redirect = 1'b1;
        end
        // a full stack holds the request back until a return frees a slot
        if (boundary && !redirect && st.int_flag && !full) begin
            next_pc  = int_vector_i[PC_W-1:0];
            redirect = 1'b1;
            push     = 1'b1;
            ack      = 1'b1;
        end
    end

    // next state of the whole sequencer
    always_comb begin
        next_st       = st;
        next_st.ack   = ack;
        next_st.rdata = pss_pkg::RD_ZERO;
        unique case (st.phase)
            pss_pkg::PH_T1: next_st.phase = pss_pkg::PH_T2;
            pss_pkg::PH_T2: next_st.phase = pss_pkg::PH_T3;
            pss_pkg::PH_T3: next_st.phase = pss_pkg::PH_T4;
            pss_pkg::PH_T4: next_st.phase = pss_pkg::PH_T1;
            default:        next_st.phase = pss_pkg::PH_T1;
        endcase
        if (boundary) begin
            // counter moves as the next first phase starts
            next_st.pc       = next_pc;
            // fetched word becomes the executing one, or a dummy slot
            next_st.instr    = instr_i;
            next_st.valid    = !redirect;
            next_st.pcl_pend = 1'b0;
        end
        // a write in the boundary cycle itself is kept for the next one
        if (pcl_hit) begin
            next_st.pcl_pend = 1'b1;
            next_st.pcl_data = reg_wdata_i;
        end
        // request recorded even while acknowledge is withheld; set wins
        next_st.int_flag = int_req_i || (st.int_flag && !ack);
        if (reg_rd_i && (reg_addr_i == pss_pkg::PCL_OFS)) begin
            next_st.rdata = st.pc[pss_pkg::PCL_W-1:0];
        end
    end

    // state register; reset starts at the vector with an idle slot
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st          <= '0;
            st.phase    <= pss_pkg::PH_T1;
            st.pc       <= pss_pkg::RESET_VEC[PC_W-1:0];
        end else begin
            st <= next_st;
        end
    end

    // outputs
    assign prog_addr_o  = st.pc;
    assign prog_rd_o    = (st.phase == pss_pkg::PH_T1);
    assign phase_o      = st.phase;
    assign exec_instr_o = st.instr;
    assign exec_valid_o = st.valid;
    assign int_ack_o    = st.ack;
    assign int_pend_o   = st.int_flag;
    assign reg_rdata_o  = st.rdata;

    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    logic bnd_seq;
    assign bnd_seq = boundary && st.valid && (flow_i.op == pss_pkg::OP_SEQ);

    phase_cycle_a: assert property (
        (st.phase == pss_pkg::PH_T1) |=> (st.phase == pss_pkg::PH_T2)
        ##1 (st.phase == pss_pkg::PH_T3) ##1 (st.phase == pss_pkg::PH_T4)
        ##1 (st.phase == pss_pkg::PH_T1))
        else $error("phase sequence broken");

    pc_steady_a: assert property (
        !boundary |=> $stable(st.pc))
        else $error("counter moved outside the phase edge");

    seq_rate_a: assert property (
        (bnd_seq && !st.pcl_pend && !(st.int_flag && !full))
        |=> (st.pc == $past(st.pc) + 1'b1) && st.valid)
        else $error("straight-line step wrong");

    jump_load_a: assert property (
        (boundary && st.valid && flow_i.op == pss_pkg::OP_JUMP)
        |=> (st.pc == $past(flow_i.target[PC_W-1:0])) && !st.valid
        ##4 (st.valid || int_ack_o || $past(st.pcl_pend)))
        else $error("jump load or dummy slot wrong");

    skip_dummy_a: assert property (
        (boundary && st.valid && flow_i.op == pss_pkg::OP_SKIP)
        |=> !st.valid [*4])
        else $error("skip did not idle one cycle");

    pcl_page_a: assert property (
        (bnd_seq && st.pcl_pend)
        |=> (st.pc[PC_W-1:pss_pkg::PCL_W] == $past(st.pc[PC_W-1:pss_pkg::PCL_W]))
        && (st.pc[pss_pkg::PCL_W-1:0] == $past(st.pcl_data)) && !st.valid)
        else $error("low byte jump left the page");

    pcl_read_a: assert property (
        (reg_rd_i && reg_addr_i == pss_pkg::PCL_OFS && !boundary)
        |=> (reg_rdata_o == st.pc[pss_pkg::PCL_W-1:0]))
        else $error("low byte read wrong");

    call_push_a: assert property (
        (boundary && st.valid && flow_i.op == pss_pkg::OP_CALL)
        |=> (st.pc == $past(flow_i.target[PC_W-1:0])) && (top == $past(st.pc)))
        else $error("call did not push and load");

    ret_pop_a: assert property (
        (boundary && st.valid && flow_i.op == pss_pkg::OP_RET)
        |-> pop ##1 (st.pc == $past(top)))
        else $error("return did not restore counter");

    full_hold_a: assert property (
        (boundary && full && st.int_flag)
        |-> !ack ##1 st.int_flag && !int_ack_o)
        else $error("acknowledge given on full stack");

endmodule : pss_sequencer

// >>> testbench/pss_prog_model.sv
// partner model: program memory and instruction decode for the sequencer
`timescale 1ns/100ps
module pss_prog_model (
    // fetch side
    input  wire logic [9:0]     prog_addr_i,
    output logic      [13:0]    instr_o,
    // decode side
    input  wire logic [13:0]    exec_instr_i,
    output pss_pkg::pss_flow_s  flow_o
);
    logic [13:0] mem [0:1023];

    // blank words are plain instructions carrying their own address
    initial begin
        for (int i = 0; i < 1024; i++) begin
            mem[i] = {3'h0, 11'(i)};
        end
    end

    // memory answers at all times; the sequencer picks its own sample edge
    assign instr_o = mem[prog_addr_i];

    // decode ignores the valid flag, so a discarded word still shows its class
    always_comb begin
        flow_o.target = exec_instr_i[10:0];
        case (exec_instr_i[13:11])
            3'h1:    flow_o.op = pss_pkg::OP_JUMP;
            3'h2:    flow_o.op = pss_pkg::OP_CALL;
            3'h3:    flow_o.op = pss_pkg::OP_RET;
            3'h4:    flow_o.op = pss_pkg::OP_SKIP;
            default: flow_o.op = pss_pkg::OP_SEQ;
        endcase
    end
endmodule : pss_prog_model

// >>> testbench/pss_sequencer_tb.sv
// testbench: program sequencer against a memory and decode model
`timescale 1ns/100ps
module pss_sequencer_tb;
    logic               ref_clk_i = 1'b0;
    logic               sys_rst_i = 1'b1;
    logic [9:0]         prog_addr_o;
    logic               prog_rd_o;
    logic [13:0]        instr_i;
    logic [3:0]         phase_o;
    logic [13:0]        exec_instr_o;
    logic               exec_valid_o;
    pss_pkg::pss_flow_s flow_i;
    logic               int_req_i = 1'b0;
    logic [10:0]        int_vector_i = 11'h200;
    logic               int_ack_o;
    logic               int_pend_o;
    logic [7:0]         reg_addr_i = 8'h00;
    logic [7:0]         reg_wdata_i = 8'h00;
    logic               reg_wr_i = 1'b0;
    logic               reg_rd_i = 1'b0;
    logic [7:0]         reg_rdata_o;
    int                 failures = 0;
    int                 total_checks = 0;
    logic [9:0]         last_pc = 10'h000;

    // 100 MHz clock
    initial begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    pss_sequencer u_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .prog_addr_o(prog_addr_o), .prog_rd_o(prog_rd_o), .instr_i(instr_i),
        .phase_o(phase_o), .exec_instr_o(exec_instr_o), .exec_valid_o(exec_valid_o),
        .flow_i(flow_i), .int_req_i(int_req_i), .int_vector_i(int_vector_i),
        .int_ack_o(int_ack_o), .int_pend_o(int_pend_o), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o));

    pss_prog_model u_mem (.prog_addr_i(prog_addr_o), .instr_o(instr_i),
        .exec_instr_i(exec_instr_o), .flow_o(flow_i));

    task automatic stop_test;
        if (failures == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // op codes of the model: 1 jump, 2 call, 3 ret, 4 skip
    task automatic poke(input logic [9:0] a, input logic [2:0] op, input logic [10:0] t);
        u_mem.mem[a] = {op, t};
    endtask : poke

    // bounded wait for the first phase; a hang ends the run as a failure
    task automatic wait_t1;
        int n;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end while (phase_o !== 4'h1 && n < 8);
        if (phase_o !== 4'h1) begin
            failures++;
            stop_test();
        end
    endtask : wait_t1

    // slot entry: bit 11 ack expected, bit 10 real instruction, low bits fetch address
    task automatic check_slot(input logic [11:0] e);
        chk("prog_addr", {4'h0, e[9:0]}, {4'h0, prog_addr_o});
        chk("prog_rd", 14'h0001, {13'h0, prog_rd_o});
        chk("exec_valid", {13'h0, e[10]}, {13'h0, exec_valid_o});
        chk("int_ack", {13'h0, e[11]}, {13'h0, int_ack_o});
        if (e[10]) begin
            chk("exec_instr", u_mem.mem[last_pc], exec_instr_o);
        end
        last_pc = e[9:0];
    endtask : check_slot

    task automatic walk(input logic [11:0] q[$]);
        foreach (q[i]) begin
            wait_t1();
            check_slot(q[i]);
        end
    endtask : walk

    task automatic t_reset;
        repeat (2) @(posedge ref_clk_i);
        #1;
        chk("phase", 14'h0001, {10'h0, phase_o});
        chk("pc", 14'h0000, {4'h0, prog_addr_o});
        chk("pend", 14'h0000, {13'h0, int_pend_o});
        chk("rdata", 14'h0000, {6'h0, reg_rdata_o});
        // third edge in reset; the release lands just after it
        @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        for (int k = 1; k <= 4; k++) begin
            @(posedge ref_clk_i);
            #1;
            chk("phase", 14'(1 << (k % 4)), {10'h0, phase_o});
            chk("prog_rd", {13'h0, (k % 4) == 0}, {13'h0, prog_rd_o});
        end
        check_slot(12'h401);
    endtask : t_reset

    task automatic t_jump_skip;
        walk('{12'h402, 12'h403, 12'h404, 12'h040, 12'h441});
        walk('{12'h442, 12'h043, 12'h444});
    endtask : t_jump_skip

    task automatic t_calls;
        walk('{12'h445, 12'h180, 12'h581, 12'h184, 12'h585, 12'h188, 12'h589});
        walk('{12'h18C});
    endtask : t_calls

    // interrupt on a full stack, call overflow, then unwinding
    task automatic t_irq_full;
        @(posedge ref_clk_i);
        int_req_i <= 1'b1;
        @(posedge ref_clk_i);
        int_req_i <= 1'b0;
        #1;
        chk("pend", 14'h0001, {13'h0, int_pend_o});
        walk('{12'h58D, 12'h190, 12'h591, 12'h18D, 12'hA00});
        walk('{12'h601, 12'h18D, 12'h58E, 12'h189, 12'h58A, 12'h185});
        walk('{12'h586, 12'h181, 12'h582, 12'h583});
        chk("pend", 14'h0000, {13'h0, int_pend_o});
    endtask : t_irq_full

    task automatic t_pcl;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_addr_i <= 8'h55;
        #1;
        chk("rdata", 14'h0083, {6'h0, reg_rdata_o});
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        reg_wr_i <= 1'b1;
        reg_wdata_i <= 8'h10;
        #1;
        chk("rdata", 14'h0000, {6'h0, reg_rdata_o});
        @(posedge ref_clk_i);
        reg_addr_i <= 8'h00;
        reg_wdata_i <= 8'hF0;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
        walk('{12'h1F0, 12'h5F1});
    endtask : t_pcl

    // program image, then the scenarios in order
    initial begin
        #1;
        poke(10'h003, 3'h1, 11'h040);
        poke(10'h041, 3'h4, 11'h000);
        poke(10'h044, 3'h2, 11'h180);
        poke(10'h180, 3'h2, 11'h184);
        poke(10'h184, 3'h2, 11'h188);
        poke(10'h188, 3'h2, 11'h18C);
        poke(10'h18C, 3'h2, 11'h190);
        poke(10'h190, 3'h3, 11'h000);
        poke(10'h200, 3'h3, 11'h000);
        poke(10'h18D, 3'h3, 11'h000);
        poke(10'h189, 3'h3, 11'h000);
        poke(10'h185, 3'h3, 11'h000);
        t_reset();
        t_jump_skip();
        t_calls();
        t_irq_full();
        t_pcl();
        stop_test();
    end
endmodule : pss_sequencer_tb
